// ### bench/slp_net_model.sv
// Frame source standing in for the network master
`timescale 1ns/1ps
module slp_net_model (
   input wire clk,
   output reg frameGood,
   output reg frameBad,
   output reg netTraffic
);
   initial begin
      frameGood = 1'h0;
      frameBad = 1'h0;
      netTraffic = 1'h0;
   end
   // ****
   // One frame slot: good, corrupted or bare traffic
   // ****
   task send(input bit good, input bit bad);
      begin
         @(posedge clk);
         frameGood <= good;
         frameBad <= bad;
         netTraffic <= 1'h1;
         @(posedge clk);
         frameGood <= 1'h0;
         frameBad <= 1'h0;
         netTraffic <= 1'h0;
      end
   endtask
endmodule // slp_net_model

// ### bench/slp_strap_link_pins_chk.sv
// Assertion checker for the strap and link status pins
`timescale 1ns/1ps
module slp_strap_link_pins_chk (
   input wire clk,
   input wire rst,
   input wire strap_function_enable,
   input wire frameGood,
   input wire frameBad,
   input wire netTraffic,
   input wire [7:0] cmdByte,
   input wire cmdValid,
   input wire slave_number_strap_lo,
   input wire slave_number_strap_hi,
   input wire chained_enable_input,
   input wire localDriverEnable,
   input wire bad_frame_indicator,
   input wire good_frame_indicator,
   input wire net_timeout_indicator,
   input wire [5:0] gpPortOe,
   input wire line_driver_enable_out,
   input wire cmdSelected
);
   reg first_q;
   reg strapMode_q;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         first_q <= 1'h1;
         strapMode_q <= 1'h0;
      end else begin
         first_q <= 1'h0;
         if (first_q) begin
            strapMode_q <= strap_function_enable;
         end
      end
   end
   // ****
   // Properties
   // ****
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_badLow;
      (!bad_frame_indicator) [*8];
   endsequence
   sequence s_goodLow;
      (!good_frame_indicator) [*8];
   endsequence
   property p_bad;
      frameBad |=> ##1 s_badLow;
   endproperty
   property p_good;
      frameGood |=> ##1 s_goodLow;
   endproperty
   property p_toutHold;
      !net_timeout_indicator && !netTraffic && !$past(netTraffic)
         |=> !net_timeout_indicator;
   endproperty
   property p_gpIn;
      !first_q && strapMode_q |-> gpPortOe == 6'h00;
   endproperty
   property p_selHit;
      cmdValid && cmdByte[3:2] == {slave_number_strap_hi,
         slave_number_strap_lo} |=> cmdSelected;
   endproperty
   property p_selMiss;
      cmdValid && cmdByte[3:2] != {slave_number_strap_hi,
         slave_number_strap_lo} |=> !cmdSelected;
   endproperty
   property p_drvOn;
      localDriverEnable || chained_enable_input |=> line_driver_enable_out;
   endproperty
   property p_drvOff;
      !localDriverEnable && !chained_enable_input
         |=> !line_driver_enable_out;
   endproperty
   a_bad: assert property (p_bad) else $error("bad pin not low");
   a_good: assert property (p_good) else $error("good pin not low");
   a_toutHold: assert property (p_toutHold) else $error("net_timeout_indicator rose");
   a_gpIn: assert property (p_gpIn) else $error("port driven");
   a_selHit: assert property (p_selHit) else $error("no select");
   a_selMiss: assert property (p_selMiss) else $error("bad select");
   a_drvOn: assert property (p_drvOn) else $error("enable low");
   a_drvOff: assert property (p_drvOff) else $error("enable high");
endmodule // slp_strap_link_pins_chk
bind slp_strap_link_pins slp_strap_link_pins_chk u_chk (
   .clk, .rst, .strap_function_enable, .frameGood, .frameBad, .netTraffic,
   .cmdByte, .cmdValid, .slave_number_strap_lo, .slave_number_strap_hi,
   .chained_enable_input, .localDriverEnable, .bad_frame_indicator,
   .good_frame_indicator, .net_timeout_indicator, .gpPortOe,
   .line_driver_enable_out, .cmdSelected
);

// ### bench/slp_strap_link_pins_tb.sv
// Self-checking bench for the strap and link status pins
`timescale 1ns/1ps
module slp_strap_link_pins_tb;
   localparam SHORT = 320;
   localparam LEDC = 50;
   localparam WDU = 10;
   reg clk = 1'h0, rst = 1'h1, refclk_select_strap = 1'h1, regWr = 1'h0;
   reg line_speed_strap_lo = 1'h0, line_speed_strap_hi = 1'h0;
   reg strap_function_enable = 1'h1, cmdValid = 1'h0, regRd = 1'h0;
   reg slave_number_strap_lo = 1'h0, slave_number_strap_hi = 1'h1;
   reg chained_enable_input = 1'h0, localDriverEnable = 1'h0;
   reg [7:0] cmdByte = 8'h00, regWdata = 8'h00;
   reg [3:0] regAddr = 4'h0;
   reg [5:0] gpPortIn = 6'h2D;
   reg [2:0] pinStrap = 3'h5;
   wire frameGood, frameBad, netTraffic, irqN, cmdSelected, refclkIs80;
   wire bad_frame_indicator, badFrameOe, good_frame_indicator, goodFrameOe;
   wire net_timeout_indicator, timeoutOe, line_driver_enable_out;
   wire [7:0] regRdata;
   wire [5:0] gpPortOe, station_number_strap;
   wire [1:0] lineSpeed;
   wire [2:0] virtual_station_count_strap;
   wire badFrameIn = badFrameOe ? bad_frame_indicator : pinStrap[0];
   wire goodFrameIn = goodFrameOe ? good_frame_indicator : pinStrap[1];
   wire timeoutIn = timeoutOe ? net_timeout_indicator : pinStrap[2];
   integer err_total = 0, n_checks = 0, i;
   slp_net_model net (.clk, .frameGood, .frameBad, .netTraffic);
   slp_strap_link_pins #(.LED_CYC(LEDC), .WD_UNIT_CYC(WDU)) DUT (
      .clk, .rst, .refclk_select_strap, .line_speed_strap_lo,
      .line_speed_strap_hi, .strap_function_enable, .frameGood, .frameBad,
      .netTraffic, .cmdByte, .cmdValid, .slave_number_strap_lo,
      .slave_number_strap_hi, .chained_enable_input, .localDriverEnable,
      .gpPortIn, .badFrameIn, .goodFrameIn, .timeoutIn, .regAddr, .regWdata,
      .regWr, .regRd, .regRdata, .bad_frame_indicator, .badFrameOe,
      .good_frame_indicator, .goodFrameOe, .net_timeout_indicator,
      .timeoutOe, .gpPortOe, .line_driver_enable_out, .irqN, .cmdSelected,
      .lineSpeed, .refclkIs80, .station_number_strap,
      .virtual_station_count_strap
   );
   initial begin
      forever #5 clk = ~clk;
   end
   // ****
   // Tasks
   // ****
   task chk(input [15:0] got, input [15:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            err_total = err_total + 1;
         end
      end
   endtask
   task wr(input [3:0] a, input [7:0] d);
      begin
         @(posedge clk);
         regWr <= 1'h1;
         regAddr <= a;
         regWdata <= d;
         @(posedge clk);
         regWr <= 1'h0;
      end
   endtask
   task rd(input [3:0] a, input [7:0] e);
      begin
         @(posedge clk);
         regRd <= 1'h1;
         regAddr <= a;
         @(posedge clk);
         regRd <= 1'h0;
         #1 chk(regRdata, e);
      end
   endtask
   task frm(input bit good, input integer n);
      integer c;
      begin
         net.send(good, !good);
         c = 0;
         do begin
            @(posedge clk);
            #1 c = c + 1;
         end while ((good ? good_frame_indicator : bad_frame_indicator)
            === 1'h0 && c < 400);
         chk(c, n + 1);
      end
   endtask
   task report_and_stop;
      begin
         if (err_total == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
         end else begin
            $display("Run complete: FAIL");
         end
         $finish;
      end
   endtask
   initial begin
      #100000;
      err_total = err_total + 1;
      report_and_stop;
   end
   // ****
   // Main sequence
   // ****
   initial begin
      for (i = 0; i < 4; i = i + 1) begin
         rst <= 1'h1;
         {line_speed_strap_hi, line_speed_strap_lo} <= i[1:0];
         repeat (10) @(posedge clk);
         rst <= 1'h0;
         repeat (3) @(posedge clk);
         #1 chk(lineSpeed, i[1:0]);
      end
      chk(refclkIs80, 1'h1);
      chk(station_number_strap, 6'h2D);
      chk(virtual_station_count_strap, 3'h5);
      gpPortIn <= 6'h12;
      rd(4'h4, 8'hED);
      wr(4'h5, 8'h3F);
      rd(4'h5, 8'h00);
      chk({badFrameOe, goodFrameOe, timeoutOe, gpPortOe}, 9'h1C0);
      rd(4'hF, 8'h00);
      frm(0, SHORT);
      frm(1, SHORT);
      wr(4'h0, 8'h04);
      frm(0, LEDC);
      rd(4'h1, 8'h03);
      wr(4'h3, 8'h02);
      repeat (2) @(posedge clk);
      #1 chk(irqN, 1'h0);
      wr(4'h2, 8'h02);
      repeat (2) @(posedge clk);
      #1 chk(irqN, 1'h1);
      rd(4'h1, 8'h01);
      wr(4'h0, 8'h0B);
      wr(4'h3, 8'h04);
      net.send(0, 0);
      repeat (70) @(posedge clk);
      #1 chk(net_timeout_indicator, 1'h1);
      repeat (20) @(posedge clk);
      #1 chk({net_timeout_indicator, irqN}, 2'h0);
      net.send(0, 0);
      repeat (3) @(posedge clk);
      #1 chk(net_timeout_indicator, 1'h1);
      for (i = 0; i < 4; i = i + 1) begin
         @(posedge clk);
         cmdByte <= {4'h0, i[1:0], 2'h0};
         cmdValid <= 1'h1;
         @(posedge clk);
         cmdValid <= 1'h0;
         #1 chk(cmdSelected, i == 2);
      end
      for (i = 0; i < 4; i = i + 1) begin
         @(posedge clk);
         {chained_enable_input, localDriverEnable} <= i[1:0];
         repeat (2) @(posedge clk);
         #1 chk(line_driver_enable_out, i != 0);
      end
      rst <= 1'h1;
      strap_function_enable <= 1'h0;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      wr(4'h5, 8'h3F);
      repeat (2) @(posedge clk);
      #1 chk(gpPortOe, 6'h3F);
      report_and_stop;
   end
endmodule // slp_strap_link_pins_tb

// ### src/slp_defs.vh
// Constants for the strap and link status pin block
`ifndef SLP_DEFS_VH
`define SLP_DEFS_VH
// ****************************************************
// Timing
// ****************************************************
`define SLP_CLK_MHZ 100
`define SLP_SHORT_PULSE_NS 3200
`define SLP_SHORT_PULSE_CYC ((`SLP_SHORT_PULSE_NS * `SLP_CLK_MHZ) / 1000)
`define SLP_LED_PULSE_MS 100
`define SLP_LED_PULSE_CYC (`SLP_LED_PULSE_MS * 1000 * `SLP_CLK_MHZ)
`define SLP_WD_UNIT_US 100
`define SLP_WD_UNIT_CYC (`SLP_WD_UNIT_US * `SLP_CLK_MHZ)
// ****************************************************
// Register offsets
// ****************************************************
`define SLP_REG_ENV1 4'h0
`define SLP_REG_STATUS 4'h1
`define SLP_REG_IRQ_CLR 4'h2
`define SLP_REG_IRQ_EN 4'h3
`define SLP_REG_STRAPS 4'h4
`define SLP_REG_GPDIR 4'h5
// ****************************************************
// Fields of environment_config_one
// ****************************************************
`define SLP_ENV1_PERIOD_LSB 0
`define SLP_ENV1_PERIOD_MSB 1
`define SLP_ENV1_LED_BIT 2
`define SLP_ENV1_TOIRQ_BIT 3
`define SLP_ENV1_RESET 8'h00
// ****************************************************
// Status bits
// ****************************************************
`define SLP_ST_BAD 0
`define SLP_ST_GOOD 1
`define SLP_ST_TIMEOUT 2
`define SLP_ST_WIDTH 3
// ****************************************************
// Line speed codes
// ****************************************************
`define SLP_SPD_2M5 2'b00
`define SLP_SPD_5M 2'b01
`define SLP_SPD_10M 2'b10
`define SLP_SPD_20M 2'b11
`endif

// ### src/slp_pulse_stretch.v
// Retriggerable active-low pulse stretcher
`timescale 1ns/1ps
module slp_pulse_stretch #(
   parameter CW = 24
) (
   input wire clk,
   input wire rst,
   input wire trig,
   input wire [CW-1:0] len,
   output reg outN
);
   reg [CW-1:0] cnt_q;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= {CW{1'b0}};
         outN <= 1'b1;
      end else if (trig) begin
         cnt_q <= len - {{(CW-1){1'b0}}, 1'b1};
         outN <= 1'b0;
      end else if (cnt_q != {CW{1'b0}}) begin
         cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
         outN <= 1'b0;
      end else begin
         outN <= 1'b1;
      end
   end
endmodule // slp_pulse_stretch

// ### src/slp_strap_link_pins.v
// Strap decoding and link status pin logic
//
// How it works
// - Reference clock strap low means a 40 MHz input, high means 80 MHz.
// - Line speed straps decode hi/lo as 11=20, 10=10, 01=5, 00=2.5 Mbps.
// - A corrupted frame pulls the bad-frame pin low for 3.2 us.
// - Corrupted frames for other stations pulse the bad-frame pin too.
// - With the LED stretch bit set the bad-frame low time is 100 ms.
// - Any valid frame pulls the good-frame pin low for 3.2 us.
// - Watchdog expiry holds the timeout pin low until traffic resumes.
// - The period field of the first config register sets the watchdog.
// - With config bit 3 and irq enable bit 2 both set, expiry raises the low irq pin.
// - Strap enable high in reset makes ports 2-7 and indicators inputs.
// - After such a reset ports 2-7 are input only, indicators output.
// - Slave straps are compared with command bits 3 and 2.
// - Internal logic runs at one fixed rate whatever the reference.
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "slp_defs.vh"
module slp_strap_link_pins #(
   parameter LED_CYC = `SLP_LED_PULSE_CYC,
   parameter WD_UNIT_CYC = `SLP_WD_UNIT_CYC
) (
   input wire clk,
   input wire rst,
   input wire refclk_select_strap,
   input wire line_speed_strap_lo,
   input wire line_speed_strap_hi,
   input wire strap_function_enable,
   input wire frameGood,
   input wire frameBad,
   input wire netTraffic,
   input wire [7:0] cmdByte,
   input wire cmdValid,
   input wire slave_number_strap_lo,
   input wire slave_number_strap_hi,
   input wire chained_enable_input,
   input wire localDriverEnable,
   input wire [5:0] gpPortIn,
   input wire badFrameIn,
   input wire goodFrameIn,
   input wire timeoutIn,
   input wire [3:0] regAddr,
   input wire [7:0] regWdata,
   input wire regWr,
   input wire regRd,
   output reg [7:0] regRdata,
   output reg bad_frame_indicator,
   output reg badFrameOe,
   output reg good_frame_indicator,
   output reg goodFrameOe,
   output reg net_timeout_indicator,
   output reg timeoutOe,
   output reg [5:0] gpPortOe,
   output reg line_driver_enable_out,
   output reg irqN,
   output reg cmdSelected,
   output reg [1:0] lineSpeed,
   output reg refclkIs80,
   output reg [5:0] station_number_strap,
   output reg [2:0] virtual_station_count_strap
);
   // ****************************************************
   // Registers
   // ****************************************************
   reg [7:0] env1_q;
   reg [5:0] gpDir_q;
   reg [`SLP_ST_WIDTH-1:0] status_q;
   reg [`SLP_ST_WIDTH-1:0] irqEn_q;
   reg strapMode_q;
   reg latched_q;
   wire badN;
   wire goodN;
   wire wdExpired;
   wire wdPulse;
   wire [23:0] badLen;
   wire [`SLP_ST_WIDTH-1:0] events;
   wire [`SLP_ST_WIDTH-1:0] clrMask;
   wire [5:0] dirWr;
   // ****************************************************
   // Local nets
   // ****************************************************
   wire [`SLP_ST_WIDTH-1:0] statusD;
   wire cmdHit;
   wire irqAny;
   genvar g;

   // ****************************************************
   // Pulse lengths
   // ****************************************************
   localparam integer SHORT_INT = `SLP_SHORT_PULSE_CYC;
   localparam [23:0] SHORT_LEN = SHORT_INT[23:0];
   localparam [23:0] LED_LEN = LED_CYC[23:0];

   // ****************************************************
   // Indicator pulses
   // ****************************************************
   assign badLen = env1_q[`SLP_ENV1_LED_BIT] ?
                   LED_LEN : SHORT_LEN;

   slp_pulse_stretch #(.CW(24)) uBad (
      .clk(clk),
      .rst(rst),
      .trig(frameBad),
      .len(badLen),
      .outN(badN)
   );

   slp_pulse_stretch #(.CW(24)) uGood (
      .clk(clk),
      .rst(rst),
      .trig(frameGood),
      .len(SHORT_LEN),
      .outN(goodN)
   );

   // ****************************************************
   // Network watchdog
   // ****************************************************
   slp_watchdog #(.UNIT(WD_UNIT_CYC), .CW(24)) uWd (
      .clk(clk),
      .rst(rst),
      .traffic(netTraffic),
      .period(env1_q[`SLP_ENV1_PERIOD_MSB:`SLP_ENV1_PERIOD_LSB]),
      .expired(wdExpired),
      .expiredPulse(wdPulse)
   );

   // ****************************************************
   // Strap capture
   // ****************************************************
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         strapMode_q <= 1'b0;
         latched_q <= 1'b0;
      end else if (!latched_q) begin
         latched_q <= 1'b1;
         strapMode_q <= strap_function_enable;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         station_number_strap <= 6'h00;
         virtual_station_count_strap <= 3'h0;
      end else if (!latched_q && strap_function_enable) begin
         station_number_strap <= gpPortIn;
         virtual_station_count_strap <=
            {timeoutIn, goodFrameIn, badFrameIn};
      end
   end

   // ****************************************************
   // Indicator pins
   // ****************************************************
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         bad_frame_indicator <= 1'b1;
      end else begin
         bad_frame_indicator <= badN;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         good_frame_indicator <= 1'b1;
      end else begin
         good_frame_indicator <= goodN;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         net_timeout_indicator <= 1'b1;
      end else begin
         net_timeout_indicator <= ~wdExpired;
      end
   end

   // ****************************************************
   // Pin directions
   // ****************************************************
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         badFrameOe <= 1'b0;
      end else begin
         badFrameOe <= latched_q;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         goodFrameOe <= 1'b0;
      end else begin
         goodFrameOe <= latched_q;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         timeoutOe <= 1'b0;
      end else begin
         timeoutOe <= latched_q;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         gpPortOe <= 6'h00;
      end else begin
         gpPortOe <= (latched_q && !strapMode_q) ?
                     gpDir_q : 6'h00;
      end
   end

   // ****************************************************
   // Line driver chain
   // ****************************************************
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         line_driver_enable_out <= 1'b0;
      end else begin
         line_driver_enable_out <= localDriverEnable | chained_enable_input;
      end
   end

   // ****************************************************
   // Strap decode
   // ****************************************************
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         lineSpeed <= `SLP_SPD_2M5;
      end else begin
         lineSpeed <= {line_speed_strap_hi, line_speed_strap_lo};
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         refclkIs80 <= 1'b0;
      end else begin
         refclkIs80 <= refclk_select_strap;
      end
   end

   // ****************************************************
   // Slave select
   // ****************************************************
   assign cmdHit = (cmdByte[3] == slave_number_strap_hi) &&
                   (cmdByte[2] == slave_number_strap_lo);

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cmdSelected <= 1'b0;
      end else begin
         cmdSelected <= cmdValid && cmdHit;
      end
   end

   // ****************************************************
   // Interrupt
   // ****************************************************
   assign irqAny = |(status_q & irqEn_q);

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         irqN <= 1'b1;
      end else begin
         irqN <= ~irqAny;
      end
   end

   // ****************************************************
   // Status
   // ****************************************************
   assign events = {wdPulse & env1_q[`SLP_ENV1_TOIRQ_BIT],
                    frameGood, frameBad};
   assign clrMask = (regWr && regAddr == `SLP_REG_IRQ_CLR) ?
                    regWdata[`SLP_ST_WIDTH-1:0] : {`SLP_ST_WIDTH{1'b0}};
   assign dirWr = regWdata[5:0];
   generate
      for (g = 0; g < `SLP_ST_WIDTH; g = g + 1) begin : gStatus
         assign statusD[g] = (status_q[g] & ~clrMask[g]) | events[g];
      end
   endgenerate

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         status_q <= {`SLP_ST_WIDTH{1'b0}};
      end else begin
         status_q <= statusD;
      end
   end

   // ****************************************************
   // Config registers
   // ****************************************************
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         env1_q <= `SLP_ENV1_RESET;
      end else if (regWr && regAddr == `SLP_REG_ENV1) begin
         env1_q <= regWdata;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         irqEn_q <= {`SLP_ST_WIDTH{1'b0}};
      end else if (regWr && regAddr == `SLP_REG_IRQ_EN) begin
         irqEn_q <= regWdata[`SLP_ST_WIDTH-1:0];
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         gpDir_q <= 6'h00;
      end else if (regWr && regAddr == `SLP_REG_GPDIR) begin
         gpDir_q <= strapMode_q ? 6'h00 : dirWr;
      end
   end

   // ****************************************************
   // Read back
   // ****************************************************
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         regRdata <= 8'h00;
      end else if (regRd) begin
         case (regAddr)
            `SLP_REG_ENV1: regRdata <= env1_q;
            `SLP_REG_STATUS: regRdata <= {5'h00, status_q};
            `SLP_REG_IRQ_EN: regRdata <= {5'h00, irqEn_q};
            `SLP_REG_STRAPS: regRdata <= {refclkIs80, strapMode_q,
                                          station_number_strap};
            `SLP_REG_GPDIR: regRdata <= {2'b00, gpDir_q};
            default: regRdata <= 8'h00;
         endcase
      end else begin
         regRdata <= 8'h00;
      end
   end

endmodule // slp_strap_link_pins

// ### src/slp_watchdog.v
// Network watchdog with selectable period
`timescale 1ns/1ps
module slp_watchdog #(
   parameter UNIT = 10000,
   parameter CW = 24
) (
   input wire clk,
   input wire rst,
   input wire traffic,
   input wire [1:0] period,
   output reg expired,
   output reg expiredPulse
);
   reg [CW-1:0] unit_q;
   reg [5:0] units_q;
   wire [5:0] limit;
   assign limit = 6'h01 << period;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         unit_q <= {CW{1'b0}};
         units_q <= 6'h00;
         expired <= 1'b0;
         expiredPulse <= 1'b0;
      end else begin
         expiredPulse <= 1'b0;
         if (traffic) begin
            unit_q <= {CW{1'b0}};
            units_q <= 6'h00;
            expired <= 1'b0;
         end else if (!expired) begin
            if (unit_q == UNIT[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}) begin
               unit_q <= {CW{1'b0}};
               if (units_q + 6'h01 >= limit) begin
                  expired <= 1'b1;
                  expiredPulse <= 1'b1;
               end else begin
                  units_q <= units_q + 6'h01;
               end
            end else begin
               unit_q <= unit_q + {{(CW-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule // slp_watchdog
